// ==== hdl/bcrtc_pkg.sv ====
// ****************************************************************
// Shared constants for the BCD calendar clock
// ****************************************************************
package bcrtc_pkg;
  // Register byte offsets
  localparam logic [4:0]  OFS_MAIN   = 5'h00;
  localparam logic [4:0]  OFS_TRIM   = 5'h04;
  localparam logic [4:0]  OFS_HOUR   = 5'h08;
  localparam logic [4:0]  OFS_MINSEC = 5'h0C;
  localparam logic [4:0]  OFS_YRMON  = 5'h10;
  localparam logic [4:0]  OFS_DAYWK  = 5'h14;
  localparam logic [4:0]  OFS_ATIME  = 5'h18;
  localparam logic [4:0]  OFS_ADATE  = 5'h1C;
  // Field positions in rtc_main_control
  localparam int          KEY_LSB    = 20;
  localparam int          LEAP_BIT   = 19;
  localparam int          PF_BIT     = 18;
  localparam int          WF_BIT     = 17;
  localparam int          AF_BIT     = 16;
  localparam int          PEN_BIT    = 5;
  localparam int          WEN_BIT    = 4;
  localparam int          AEN_BIT    = 3;
  localparam int          H12_BIT    = 2;
  localparam int          OSC_BIT    = 1;
  localparam int          EN_BIT     = 0;
  // Field positions in rtc_trim_and_period
  localparam int          TRIM_LSB   = 16;
  localparam int          FAST_BIT   = 4;
  localparam logic [3:0]  UNLOCK_KEY = 4'h6;
  // Reset values of the calendar and alarm date
  localparam logic [7:0]  RST_YEAR   = 8'h12;
  localparam logic [4:0]  RST_MONTH  = 5'h01;
  localparam logic [5:0]  RST_DAY    = 6'h01;
  localparam logic [2:0]  RST_WDAY   = 3'h0;
  localparam logic [23:0] ADATE_RST  = 24'h120101;
  // Writable bits of the alarm registers
  localparam logic [22:0] ATIME_MASK = 23'h7F7F7F;
  localparam logic [23:0] ADATE_MASK = 24'hFF1F3F;
  // Slow clock cycles per second, and the periodic base of 1/128 s
  localparam logic [16:0] SEC_CYCLES = 17'h08000;
  localparam int          PER_LOG2   = 8;
  // One trim step moves one cycle per window of 16 s, about 2 ppm
  localparam logic [3:0]  TRIM_WIN   = 4'hF;
  localparam logic [5:0]  TRIM_MAX   = 6'h3F;
  typedef enum logic [2:0] {
    PW_IDLE = 3'b001,
    PW_ONE  = 3'b010,
    PW_TWO  = 3'b100
  } bcrtc_pw_t;
endpackage

// ==== hdl/bcrtc_core.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ns
module bcrtc_core
  import bcrtc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        slow_crystal,
  input  wire logic        slow_crystal_on,
  input  wire logic        slow_internal_osc,
  input  wire logic        fast_clock,
  input  wire logic [6:0]  trim_boot_value,
  output logic             wakeup_req
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0]  key,        next_key;
  logic        en,         next_en;
  logic        osc_sel,    next_osc_sel;
  logic        h12,        next_h12;
  logic        aen,        next_aen;
  logic        wen,        next_wen;
  logic        pen,        next_pen;
  logic        fast_sel,   next_fast_sel;
  logic [6:0]  trim_value, next_trim_value;
  logic [2:0]  interval,   next_interval;
  logic        boot_done,  next_boot_done;
  logic [22:0] alarm_t,    next_alarm_t;
  logic [23:0] alarm_d,    next_alarm_d;
  logic        alarm_flag, next_alarm_flag;
  logic        per_flag,   next_per_flag;
  logic        wake_flag,  next_wake_flag;
  logic        sec_adv_q,  next_sec_adv_q;
  bcrtc_pw_t   pw_state,   next_pw_state;
  logic [4:0]  pw_addr,    next_pw_addr;
  logic [31:0] pw_data,    next_pw_data;
  logic [31:0] next_rd_data;
  logic [6:0]  hour,       next_hour;
  logic [6:0]  minute,     next_minute;
  logic [6:0]  second,     next_second;
  logic [7:0]  year,       next_year;
  logic [4:0]  month,      next_month;
  logic [5:0]  day,        next_day;
  logic [2:0]  wday,       next_wday;
  logic [16:0] div,        next_div;
  logic [3:0]  win,        next_win;
  logic        src_q,      next_src_q;

  logic        src;
  logic        raw_edge;
  logic        rtc_tick;
  logic        wr_ok;
  logic        leap;
  logic [16:0] sec_len;
  logic        sec_tick;
  logic [16:0] pmask;
  logic        per_evt;
  logic        match;
  logic        pw_apply;
  logic        pw_accept;
  logic [5:0]  dim;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] x);
    return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
  endfunction

  // Only years divisible by four inside 20xx; 2100 never arises
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [5:0] days_in(input logic [4:0] m, input logic lp);
    case (m)
      5'h02:                      return lp ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default:                    return 6'h31;
    endcase
  endfunction

  // ****************************************************************
  // Clock source, divider and events
  // ****************************************************************
  // Pick the slow source; a crystal that is not running falls back
  assign src      = fast_sel ? fast_clock :
                    (osc_sel | ~slow_crystal_on) ? slow_internal_osc : slow_crystal;
  assign raw_edge = src & ~src_q;
  assign rtc_tick = en & raw_edge;
  assign wr_ok    = wr_en & (key == UNLOCK_KEY);
  assign leap     = is_leap(year);
  assign dim      = days_in(month, leap);
  // Once per 16 s window the second is shortened or stretched by the step count
  assign sec_len  = (win != TRIM_WIN || trim_value[5:0] == 6'h00) ? SEC_CYCLES :
                    trim_value[6] ? SEC_CYCLES + {11'h000, trim_value[5:0]} :
                    SEC_CYCLES - {11'h000, trim_value[5:0]};
  assign sec_tick = rtc_tick & (div == sec_len - 17'h00001);
  assign pmask    = ~(17'h1FFFF << (PER_LOG2 + 32'(interval)));
  // The 1 s interval follows the trimmed second itself
  assign per_evt  = (interval == 3'h7) ? sec_tick : rtc_tick & ((div & pmask) == pmask);
  assign match    = (alarm_t == {hour, 1'b0, minute, 1'b0, second}) &&
                    (alarm_d == {year, 3'h0, month, 2'h0, day});
  assign pw_apply = (pw_state == PW_TWO) & raw_edge;
  // A 12-hour write with an hour above 12 is dropped whole
  assign pw_accept = wr_ok && (addr == OFS_HOUR || addr == OFS_MINSEC ||
                     addr == OFS_YRMON || addr == OFS_DAYWK) &&
                     !(addr == OFS_HOUR && h12 && wdata[5:0] > 6'h12);
  assign wakeup_req = wake_flag;

  // ****************************************************************
  // Control, bus and flags
  // ****************************************************************
  // Next values of the control registers, the flags and read data
  always_comb begin
    logic al_set;
    logic per_set;
    logic clr_main;
    al_set          = aen & match & sec_adv_q;
    per_set         = pen & per_evt;
    clr_main        = wr_ok && addr == OFS_MAIN;
    next_key        = key;
    next_en         = en;
    next_osc_sel    = osc_sel;
    next_h12        = h12;
    next_aen        = aen;
    next_wen        = wen;
    next_pen        = pen;
    next_fast_sel   = fast_sel;
    next_trim_value = trim_value;
    next_interval   = interval;
    next_boot_done  = 1'b1;
    next_alarm_t    = alarm_t;
    next_alarm_d    = alarm_d;
    next_sec_adv_q  = sec_tick;
    next_pw_state   = pw_state;
    next_pw_addr    = pw_addr;
    next_pw_data    = pw_data;
    next_rd_data    = 32'h00000000;
    // The key itself stays writable, or the lock could never open
    if (wr_en && addr == OFS_MAIN) begin
      next_key = wdata[KEY_LSB +: 4];
    end
    if (wr_ok) begin
      case (addr)
        OFS_MAIN: begin
          next_en      = wdata[EN_BIT];
          next_osc_sel = wdata[OSC_BIT];
          next_h12     = wdata[H12_BIT];
          next_aen     = wdata[AEN_BIT];
          next_wen     = wdata[WEN_BIT];
          next_pen     = wdata[PEN_BIT];
        end
        OFS_TRIM: begin
          next_trim_value = wdata[TRIM_LSB +: 7];
          next_fast_sel   = wdata[FAST_BIT];
          next_interval   = wdata[2:0];
        end
        OFS_ATIME: next_alarm_t = wdata[22:0] & ATIME_MASK;
        OFS_ADATE: next_alarm_d = wdata[23:0] & ADATE_MASK;
        default: begin
        end
      endcase
    end
    // Only the last time write is kept while one waits; a newer one restarts it
    if (pw_accept) begin
      next_pw_state = PW_ONE;
      next_pw_addr  = addr;
      next_pw_data  = wdata;
    end else if (raw_edge) begin
      case (pw_state)
        PW_ONE:  next_pw_state = PW_TWO;
        PW_TWO:  next_pw_state = PW_IDLE;
        PW_IDLE: next_pw_state = PW_IDLE;
        default: next_pw_state = PW_IDLE;
      endcase
    end
    if (!boot_done) begin
      next_trim_value = trim_boot_value;
    end
    // Set beats a clear in the same cycle
    next_alarm_flag = al_set | (alarm_flag & ~(clr_main & ~wdata[AF_BIT]));
    next_per_flag   = per_set | (per_flag & ~(clr_main & ~wdata[PF_BIT]));
    next_wake_flag  = (wen & (al_set | per_set)) |
                      (wake_flag & (next_alarm_flag | next_per_flag));
    if (rd_en) begin
      case (addr)
        OFS_MAIN:   next_rd_data = {8'h00, key, leap, per_flag, wake_flag, alarm_flag,
                                    10'h000, pen, wen, aen, h12, osc_sel, en};
        OFS_TRIM:   next_rd_data = {9'h000, trim_value, 11'h000, fast_sel, 1'b0, interval};
        OFS_HOUR:   next_rd_data = {25'h0000000, hour};
        OFS_MINSEC: next_rd_data = {9'h000, minute, 9'h000, second};
        OFS_YRMON:  next_rd_data = {8'h00, year, 11'h000, month};
        OFS_DAYWK:  next_rd_data = {10'h000, day, 13'h0000, wday};
        OFS_ATIME:  next_rd_data = {9'h000, alarm_t};
        OFS_ADATE:  next_rd_data = {8'h00, alarm_d};
        default:    next_rd_data = 32'h00000000;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      key        <= 4'h0;
      en         <= 1'b0;
      osc_sel    <= 1'b0;
      h12        <= 1'b0;
      aen        <= 1'b0;
      wen        <= 1'b0;
      pen        <= 1'b0;
      fast_sel   <= 1'b0;
      trim_value <= 7'h00;
      interval   <= 3'h0;
      boot_done  <= 1'b0;
      alarm_t    <= 23'h000000;
      alarm_d    <= ADATE_RST;
      alarm_flag <= 1'b0;
      per_flag   <= 1'b0;
      wake_flag  <= 1'b0;
      sec_adv_q  <= 1'b0;
      pw_state   <= PW_IDLE;
      pw_addr    <= 5'h00;
      pw_data    <= 32'h00000000;
      rd_data    <= 32'h00000000;
    end else begin
      key        <= next_key;
      en         <= next_en;
      osc_sel    <= next_osc_sel;
      h12        <= next_h12;
      aen        <= next_aen;
      wen        <= next_wen;
      pen        <= next_pen;
      fast_sel   <= next_fast_sel;
      trim_value <= next_trim_value;
      interval   <= next_interval;
      boot_done  <= next_boot_done;
      alarm_t    <= next_alarm_t;
      alarm_d    <= next_alarm_d;
      alarm_flag <= next_alarm_flag;
      per_flag   <= next_per_flag;
      wake_flag  <= next_wake_flag;
      sec_adv_q  <= next_sec_adv_q;
      pw_state   <= next_pw_state;
      pw_addr    <= next_pw_addr;
      pw_data    <= next_pw_data;
      rd_data    <= next_rd_data;
    end
  end

  // ****************************************************************
  // Timekeeping
  // ****************************************************************
  // Carry chain second to year; a due write overrides the count
  always_comb begin
    logic [7:0] t_s;
    logic [7:0] t_m;
    logic [7:0] t_h;
    logic [7:0] t_d;
    logic [7:0] t_mo;
    logic [7:0] t_y;
    logic [5:0] h_top;
    logic       c_min;
    logic       c_hr;
    logic       c_day;
    t_s     = bcd_inc({1'b0, second});
    t_m     = bcd_inc({1'b0, minute});
    t_h     = bcd_inc({2'h0, hour[5:0]});
    t_d     = bcd_inc({2'h0, day});
    t_mo    = bcd_inc({3'h0, month});
    t_y     = bcd_inc(year);
    h_top   = h12 ? 6'h11 : 6'h23;
    c_min   = sec_tick && second == 7'h59;
    c_hr    = c_min && minute == 7'h59;
    c_day   = c_hr && hour[5:0] == h_top && (!h12 || hour[6]);
    next_second = second;
    next_minute = minute;
    next_hour   = hour;
    next_day    = day;
    next_wday   = wday;
    next_month  = month;
    next_year   = year;
    next_src_q  = src;
    next_div    = div;
    next_win    = win;
    if (rtc_tick) begin
      next_div = sec_tick ? 17'h00000 : div + 17'h00001;
    end
    if (sec_tick) begin
      next_win    = win + 4'h1;
      next_second = (second == 7'h59) ? 7'h00 : t_s[6:0];
    end
    if (c_min) begin
      next_minute = (minute == 7'h59) ? 7'h00 : t_m[6:0];
    end
    // In 12-hour form 11 rolls to 0 and flips the PM bit
    if (c_hr) begin
      next_hour = (hour[5:0] == h_top) ? {hour[6] ^ h12, 6'h00} : {hour[6], t_h[5:0]};
    end
    if (c_day) begin
      next_wday = (wday == 3'h6) ? 3'h0 : wday + 3'h1;
      next_day  = (day == dim) ? 6'h01 : t_d[5:0];
      if (day == dim) begin
        next_month = (month == 5'h12) ? 5'h01 : t_mo[4:0];
        if (month == 5'h12) begin
          next_year = (year == 8'h99) ? 8'h00 : t_y;
        end
      end
    end
    if (pw_apply) begin
      case (pw_addr)
        OFS_HOUR: next_hour = pw_data[6:0];
        OFS_MINSEC: begin
          next_minute = pw_data[22:16];
          next_second = pw_data[6:0];
        end
        OFS_YRMON: begin
          next_year  = pw_data[23:16];
          next_month = pw_data[4:0];
        end
        OFS_DAYWK: begin
          next_day  = pw_data[21:16];
          next_wday = pw_data[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Time and calendar registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      second <= 7'h00;
      minute <= 7'h00;
      hour   <= 7'h00;
      day    <= RST_DAY;
      wday   <= RST_WDAY;
      month  <= RST_MONTH;
      year   <= RST_YEAR;
      src_q  <= 1'b0;
      div    <= 17'h00000;
      win    <= 4'h0;
    end else begin
      second <= next_second;
      minute <= next_minute;
      hour   <= next_hour;
      day    <= next_day;
      wday   <= next_wday;
      month  <= next_month;
      year   <= next_year;
      src_q  <= next_src_q;
      div    <= next_div;
      win    <= next_win;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Counts slow edges since the last accepted time write
  logic [1:0] edges_seen;
  always_ff @(posedge ref_clk) begin
    if (!rstn || pw_accept) begin
      edges_seen <= 2'h0;
    end else if (raw_edge && edges_seen != 2'h3) begin
      edges_seen <= edges_seen + 2'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reset_time: assert property ($rose(rstn) |-> hour == 7'h00 && minute == 7'h00 && !h12
    && year == RST_YEAR && month == RST_MONTH && day == RST_DAY) else $error("bad reset time");
  a_write_delay: assert property (pw_apply |-> edges_seen == 2'h1)
    else $error("time write applied at wrong edge");
  a_key_lock: assert property (wr_en && addr == OFS_TRIM && key != UNLOCK_KEY && boot_done
    |=> $stable(trim_value) && $stable(interval)) else $error("locked write took effect");
  a_invalid_hour: assert property (wr_en && addr == OFS_HOUR && h12 && wdata[5:0] > 6'h12
    && pw_state == PW_IDLE |=> pw_state == PW_IDLE) else $error("invalid hour accepted");
  a_wrap_24: assert property (sec_tick && !h12 && !pw_apply && hour == 7'h23 && minute == 7'h59
    && second == 7'h59 |=> hour == 7'h00 && second == 7'h00) else $error("24 hour wrap wrong");
  a_wrap_12: assert property (sec_tick && h12 && !pw_apply && hour[5:0] == 6'h11 && minute == 7'h59
    && second == 7'h59 |=> hour[5:0] == 6'h00 && hour[6] != $past(hour[6])) else $error("12 hour wrap wrong");
  a_alarm_set: assert property (aen && match && sec_adv_q |=> alarm_flag [*2])
    else $error("alarm flag missed");
  a_flag_hold: assert property (per_flag && !(wr_ok && addr == OFS_MAIN && !wdata[PF_BIT])
    |=> per_flag) else $error("periodic flag lost");
  a_wake_set: assert property (wen && pen && per_evt |=> wake_flag && per_flag)
    else $error("wake flag missed");
  a_leap_read: assert property (rd_en && addr == OFS_MAIN |=> rd_data[LEAP_BIT] == $past(leap))
    else $error("leap flag read wrong");
  a_year_roll: assert property (sec_tick && !pw_apply && year == 8'h99 && month == 5'h12 && day == 6'h31
    && hour[5:0] == (h12 ? 6'h11 : 6'h23) && (!h12 || hour[6]) && minute == 7'h59 && second == 7'h59
    |=> year == 8'h00 && month == 5'h01 && day == 6'h01) else $error("year rollover wrong");
endmodule

// ==== tb/tb_bcrtc_core.sv ====
`timescale 1ns/1ns
module tb_bcrtc_core;
  import bcrtc_pkg::*;
  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  logic        ref_clk;
  logic        rstn;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        slow_crystal      = 1'b0;
  logic        slow_internal_osc = 1'b0;
  logic        slow_crystal_on;
  logic        fast_clock        = 1'b0;
  logic        wakeup_req;
  logic [3:0]  sdiv              = 4'h0;
  logic [31:0] d;
  logic [31:0] mdl [8];
  int          fail_count;
  int          checks;
  int          seed;
  int          i;
  int          wd;
  int          tv;
  int          n;
  int          cyc = 0;

  bcrtc_core dut (
    .ref_clk           (ref_clk),
    .rstn              (rstn),
    .addr              (addr),
    .wdata             (wdata),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .rd_data           (rd_data),
    .slow_crystal      (slow_crystal),
    .slow_crystal_on   (slow_crystal_on),
    .slow_internal_osc (slow_internal_osc),
    .fast_clock        (fast_clock),
    .trim_boot_value   (7'h45),
    .wakeup_req        (wakeup_req)
  );

  // 25 MHz bus clock
  always #20 ref_clk = ~ref_clk;

  // Crystal every 8, internal every 4, fast every 16 bus cycles: distinct rates make the source visible
  always @(posedge ref_clk) begin
    sdiv              <= sdiv + 4'h1;
    slow_crystal      <= sdiv[2];
    slow_internal_osc <= sdiv[1];
    fast_clock        <= sdiv[3];
  end

  // Free cycle count for measuring event spacing
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so it is taken there
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Time writes land after two slow edges; 24 cycles covers that at this rate
  task automatic settle();
    repeat (24) @(posedge ref_clk);
  endtask

  // Cycles between two periodic events; each is cleared so the next shows, the first may be irregular
  task automatic gap(output int cnt);
    int t0;
    wr(OFS_MAIN, 32'h00600035);
    @(posedge ref_clk);
    while (wakeup_req !== 1'b1) @(posedge ref_clk);
    t0 = cyc;
    wr(OFS_MAIN, 32'h00600035);
    @(posedge ref_clk);
    while (wakeup_req !== 1'b1) @(posedge ref_clk);
    cnt = cyc - t0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected fourteen thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0; rstn = 1'b0; addr = 5'h00; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
    slow_crystal_on = 1'b1;
    fail_count = 0; checks = 0; seed = 32'h994136db;
    mdl = '{32'h00080000, 32'h00450000, 32'h0, 32'h0, 32'h00120001, 32'h00010000, 32'h0, 32'h00120101};
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // Reset values of every register, trim from the boot value
    for (i = 0; i < 8; i++) begin
      rd(5'(i * 4), d);
      chk("reset", mdl[i], d);
    end
    rd(5'h02, d);
    chk("unmapped", 32'h0, d);
    // Locked bank ignores a time write
    wr(OFS_HOUR, 32'h00000015);
    settle();
    rd(OFS_HOUR, d);
    chk("locked", mdl[2], d);
    wr(OFS_TRIM, 32'h007F0007);
    rd(OFS_TRIM, d);
    chk("locked_trim", mdl[1], d);
    wr(OFS_MAIN, 32'h00600000);
    rd(OFS_MAIN, d);
    chk("unlock", 32'h00680000, d);
    // Pending write is not visible until two slow edges pass
    wr(OFS_HOUR, 32'h00000015);
    rd(OFS_HOUR, d);
    chk("pending", 32'h0, d);
    settle();
    rd(OFS_HOUR, d);
    chk("hour", 32'h00000015, d);
    wr(OFS_MINSEC, 32'h00590030);
    settle();
    rd(OFS_MINSEC, d);
    chk("minsec", 32'h00590030, d);
    // Twelve hour form refuses hours above 12, keeps the PM bit
    wr(OFS_MAIN, 32'h00600004);
    wr(OFS_HOUR, 32'h00000013);
    settle();
    rd(OFS_HOUR, d);
    chk("hour12bad", 32'h00000015, d);
    wr(OFS_HOUR, 32'h00000051);
    settle();
    rd(OFS_HOUR, d);
    chk("hourpm", 32'h00000051, d);
    // Random weekdays and trim values
    for (i = 0; i < 4; i++) begin
      wd = $unsigned($random(seed)) % 7;
      tv = $random(seed) & 32'h7F;
      wr(OFS_DAYWK, 32'h00010000 | wd);
      wr(OFS_TRIM, tv << 16);
      settle();
      rd(OFS_DAYWK, d);
      chk("weekday", 32'h00010000 | wd, d);
      rd(OFS_TRIM, d);
      chk("trim", tv << 16, d);
    end
    // Year 2013 is not a leap year
    wr(OFS_YRMON, 32'h00130001);
    settle();
    rd(OFS_MAIN, d);
    chk("leap", 32'h00600004, d);
    // Periodic tick at 1/128 s sets its flag and the wake flag
    wr(OFS_MAIN, 32'h00600035);
    for (i = 0; i < 4000 && wakeup_req !== 1'b1; i++) @(posedge ref_clk);
    chk("wake", 32'h1, {31'h0, wakeup_req});
    rd(OFS_MAIN, d);
    chk("pflag", 32'h00060000, d & 32'h00060000);
    wr(OFS_MAIN, 32'h00640035);
    rd(OFS_MAIN, d);
    chk("keep", 32'h00040000, d & 32'h00040000);
    wr(OFS_MAIN, 32'h00600035);
    rd(OFS_MAIN, d);
    chk("clear", 32'h0, d & 32'h00060000);
    // Missing crystal falls back to the internal oscillator; code 1 gives 512 ticks of 4 cycles
    slow_crystal_on <= 1'b0;
    wr(OFS_TRIM, 32'h00000001);
    gap(n);
    chk("gap_osc", 32'h00000800, n);
    // Fast source overrides the slow ones; code 0 gives 256 ticks of 16 cycles
    wr(OFS_TRIM, 32'h00000010);
    gap(n);
    chk("gap_fast", 32'h00001000, n);
    finish_test();
  end
endmodule
